// [design/serial_host_pkg.sv]
// Shared constants and carriers for the serial host controller.
// Assumes a single 125 MHz clock; all timing counts are derived from CLK_HZ.
package serial_host_pkg;

	// ==========================================================
	// Clock and line rates
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned OVERSAMPLE = 16;
	localparam int unsigned BAUD_9600 = 9600;
	localparam int unsigned BAUD_19200 = 19200;
	localparam int unsigned BAUD_38400 = 38400;
	localparam int unsigned BAUD_57600 = 57600;
	// Oversample divider, rounded to nearest
	localparam logic [15:0] DIV_9600 =
		16'((CLK_HZ + OVERSAMPLE * BAUD_9600 / 2) / (OVERSAMPLE * BAUD_9600));
	localparam logic [15:0] DIV_19200 =
		16'((CLK_HZ + OVERSAMPLE * BAUD_19200 / 2) / (OVERSAMPLE * BAUD_19200));
	localparam logic [15:0] DIV_38400 =
		16'((CLK_HZ + OVERSAMPLE * BAUD_38400 / 2) / (OVERSAMPLE * BAUD_38400));
	localparam logic [15:0] DIV_57600 =
		16'((CLK_HZ + OVERSAMPLE * BAUD_57600 / 2) / (OVERSAMPLE * BAUD_57600));

	// ==========================================================
	// Rate select codes
	localparam logic [1:0] SEL_9600 = 2'h0;
	localparam logic [1:0] SEL_19200 = 2'h1;
	localparam logic [1:0] SEL_38400 = 2'h2;
	localparam logic [1:0] SEL_57600 = 2'h3;
	localparam logic [1:0] SEL_RESET = SEL_9600;

	// ==========================================================
	// Character format
	localparam int unsigned FRAME_BITS = 10;
	localparam int unsigned DATA_BITS = 7;
	localparam logic [3:0] FRAME_LAST_BIT = 4'(FRAME_BITS - 1);
	localparam logic [3:0] RX_LAST_BIT = 4'(DATA_BITS);
	localparam logic [3:0] OS_LAST = 4'(OVERSAMPLE - 1);
	localparam logic [3:0] OS_HALF = 4'(OVERSAMPLE / 2 - 1);
	localparam logic [9:0] LINE_IDLE = 10'h3FF;
	localparam logic [6:0] CHAR_CR = 7'h0D;
	localparam logic [6:0] CHAR_LF = 7'h0A;
	localparam logic [6:0] CHAR_QMARK = 7'h3F;

	// ==========================================================
	// Message limits and pacing
	localparam logic [7:0] MAX_CHARS = 8'hFF;
	localparam logic [7:0] TERM_CHARS = 8'h02;
	localparam logic [7:0] MAX_USER_CHARS = 8'(MAX_CHARS - TERM_CHARS);
	localparam int unsigned GAP_MS = 50;
	localparam int unsigned GAP_CYCLES_DEF = CLK_HZ / 1000 * GAP_MS;
	localparam int unsigned RESP_TIMEOUT_MS = 1000;
	localparam int unsigned RESP_TIMEOUT_DEF = CLK_HZ / 1000 * RESP_TIMEOUT_MS;
	localparam int unsigned FIFO_DEPTH_DEF = 8;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic last;
		logic [6:0] ch;
	} txChar_s;

	typedef struct packed {
		logic parityErr;
		logic frameErr;
		logic [6:0] ch;
	} rxChar_s;

endpackage : serial_host_pkg

// [design/char_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
module char_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady
);

	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
		begin : g_bad
			$error("char_fifo: DEPTH must be a power of two of at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
	logic push, pop;

	assign inReady = (wrPtr_q - rdPtr_q) != (AW + 1)'(DEPTH);
	assign outValid = wrPtr_q != rdPtr_q;
	assign outData = mem_q[rdPtr_q[AW-1:0]];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_comb
	begin
		wrPtr_d = wrPtr_q + (AW + 1)'(push);
		rdPtr_d = rdPtr_q + (AW + 1)'(pop);
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end
		else
		begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
		end
	end

	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem_q[wrPtr_q[AW-1:0]] <= inData;
		end
	end

endmodule : char_fifo

// [design/serial_host_controller.sv]
// Host-side controller for an instrument serial command port.
// Assumes rxd/txd are the line levels (mark = 1) and the user feeds one message at a time.
module serial_host_controller
	import serial_host_pkg::*;
#(
	parameter int unsigned GAP_CYCLES = GAP_CYCLES_DEF,
	parameter int unsigned RESP_TIMEOUT_CYCLES = RESP_TIMEOUT_DEF,
	parameter int unsigned FIFO_DEPTH = FIFO_DEPTH_DEF
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [1:0] baudSel,
	input wire logic cmdValid,
	input wire txChar_s cmdChar,
	output logic cmdReady,
	input wire logic rxd,
	output logic txd,
	output logic rxValid,
	output rxChar_s rxChar,
	output logic respDone,
	output logic respTimeout,
	output logic overLength,
	output logic busy,
	output logic [1:0] baudActive
);

	generate
		if (GAP_CYCLES < 2 || RESP_TIMEOUT_CYCLES < 2)
		begin : g_bad
			$error("serial_host_controller: gap and timeout need at least 2 cycles");
		end
	endgenerate

	// ==========================================================
	// Message buffer
	txChar_s fifoChar;
	logic fifoValid, fifoPop;

	char_fifo #(
		.WIDTH($bits(txChar_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.srst(srst),
		.inValid(cmdValid),
		.inData(cmdChar),
		.inReady(cmdReady),
		.outValid(fifoValid),
		.outData(fifoChar),
		.outReady(fifoPop)
	);

	// ==========================================================
	// Oversample divider
	logic [15:0] divCnt_q, divCnt_d, divLimit;
	logic osTick;
	logic [1:0] baudSel_q, baudSel_d;

	always_comb
	begin
		case (baudSel_q)
			SEL_9600: divLimit = DIV_9600;
			SEL_19200: divLimit = DIV_19200;
			SEL_38400: divLimit = DIV_38400;
			SEL_57600: divLimit = DIV_57600;
			default: divLimit = DIV_9600;
		endcase
		// Compare with >= so a lower rate limit taken mid-count does not stall the ticks
		osTick = divCnt_q >= divLimit - 16'h0001;
		divCnt_d = osTick ? 16'h0000 : divCnt_q + 16'h0001;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			divCnt_q <= 16'h0000;
		else
			divCnt_q <= divCnt_d;
	end

	// ==========================================================
	// Transmitter
	logic txLoad;
	logic [6:0] txLoadChar;
	logic [9:0] txShift_q, txShift_d;
	logic [3:0] txOs_q, txOs_d, txBit_q, txBit_d;
	logic txBusy_q, txBusy_d, txDone;

	always_comb
	begin
		txShift_d = txShift_q;
		txOs_d = txOs_q;
		txBit_d = txBit_q;
		txBusy_d = txBusy_q;
		txDone = 1'b0;
		if (!txBusy_q && txLoad)
		begin
			// Stop, odd parity, data LSB first, start
			txShift_d = {1'b1, ~^txLoadChar, txLoadChar, 1'b0};
			txOs_d = 4'h0;
			txBit_d = 4'h0;
			txBusy_d = 1'b1;
		end
		else if (txBusy_q && osTick)
		begin
			txOs_d = txOs_q + 4'h1;
			if (txOs_q == OS_LAST)
			begin
				txShift_d = {1'b1, txShift_q[9:1]};
				txBit_d = txBit_q + 4'h1;
				if (txBit_q == FRAME_LAST_BIT)
				begin
					txBusy_d = 1'b0;
					txDone = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			txShift_q <= LINE_IDLE;
			txOs_q <= 4'h0;
			txBit_q <= 4'h0;
			txBusy_q <= 1'b0;
		end
		else
		begin
			txShift_q <= txShift_d;
			txOs_q <= txOs_d;
			txBit_q <= txBit_d;
			txBusy_q <= txBusy_d;
		end
	end

	assign txd = txShift_q[0];

	// ==========================================================
	// Receiver
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} rxState_e;
	rxState_e rxState_q, rxState_d;
	logic rxSync1_q, rxLine_q;
	logic [3:0] rxOs_q, rxOs_d, rxBit_q, rxBit_d;
	logic [7:0] rxShift_q, rxShift_d;
	logic rxValid_q, rxValid_d, rxEnable;
	rxChar_s rxChar_q, rxChar_d;

	always_comb
	begin
		rxState_d = rxState_q;
		rxOs_d = rxOs_q;
		rxBit_d = rxBit_q;
		rxShift_d = rxShift_q;
		rxValid_d = 1'b0;
		rxChar_d = rxChar_q;
		if (osTick)
		begin
			rxOs_d = rxOs_q + 4'h1;
			case (rxState_q)
				RX_IDLE:
				begin
					rxOs_d = 4'h0;
					if (rxEnable && !rxLine_q)
						rxState_d = RX_START;
				end
				RX_START:
				begin
					if (rxOs_q == OS_HALF)
					begin
						// Recheck start at mid-bit, then sample every bit centre
						rxOs_d = 4'h0;
						rxBit_d = 4'h0;
						rxState_d = rxLine_q ? RX_IDLE : RX_BITS;
					end
				end
				RX_BITS:
				begin
					if (rxOs_q == OS_LAST)
					begin
						rxShift_d = {rxLine_q, rxShift_q[7:1]};
						rxBit_d = rxBit_q + 4'h1;
						if (rxBit_q == RX_LAST_BIT)
							rxState_d = RX_STOP;
					end
				end
				RX_STOP:
				begin
					if (rxOs_q == OS_LAST)
					begin
						rxValid_d = 1'b1;
						rxChar_d.ch = rxShift_q[6:0];
						rxChar_d.parityErr = ~^rxShift_q;
						rxChar_d.frameErr = !rxLine_q;
						rxState_d = RX_IDLE;
					end
				end
				default: rxState_d = RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rxSync1_q <= 1'b1;
			rxLine_q <= 1'b1;
			rxState_q <= RX_IDLE;
			rxOs_q <= 4'h0;
			rxBit_q <= 4'h0;
			rxShift_q <= 8'h00;
			rxValid_q <= 1'b0;
			rxChar_q <= '0;
		end
		else
		begin
			rxSync1_q <= rxd;
			rxLine_q <= rxSync1_q;
			rxState_q <= rxState_d;
			rxOs_q <= rxOs_d;
			rxBit_q <= rxBit_d;
			rxShift_q <= rxShift_d;
			rxValid_q <= rxValid_d;
			rxChar_q <= rxChar_d;
		end
	end

	assign rxValid = rxValid_q;
	assign rxChar = rxChar_q;

	// ==========================================================
	// Message sequencer
	typedef enum logic [2:0] {ST_IDLE, ST_DATA, ST_CR, ST_LF, ST_FLUSH, ST_RX, ST_GAP} state_e;
	state_e state_q, state_d;
	logic [7:0] charCount_q, charCount_d;
	logic isQuery_q, isQuery_d, sawCr_q, sawCr_d;
	logic [31:0] waitCnt_q, waitCnt_d;
	logic respDone_q, respDone_d, respTimeout_q, respTimeout_d;
	logic overLength_q, overLength_d;

	assign rxEnable = state_q == ST_RX;

	always_comb
	begin
		state_d = state_q;
		charCount_d = charCount_q;
		isQuery_d = isQuery_q;
		sawCr_d = sawCr_q;
		waitCnt_d = waitCnt_q;
		baudSel_d = baudSel_q;
		respDone_d = 1'b0;
		respTimeout_d = 1'b0;
		overLength_d = 1'b0;
		txLoad = 1'b0;
		txLoadChar = CHAR_CR;
		fifoPop = 1'b0;
		case (state_q)
			ST_IDLE:
			begin
				baudSel_d = baudSel;
				if (fifoValid)
				begin
					state_d = ST_DATA;
					charCount_d = 8'h00;
					isQuery_d = 1'b0;
				end
			end
			ST_DATA:
			begin
				// Semicolon-chained segments pass through in one transmission
				if (fifoValid && !txBusy_q)
				begin
					fifoPop = 1'b1;
					if (charCount_q < MAX_USER_CHARS)
					begin
						txLoad = 1'b1;
						txLoadChar = fifoChar.ch;
						charCount_d = charCount_q + 8'h01;
						if (fifoChar.ch == CHAR_QMARK)
							isQuery_d = 1'b1;
					end
					else
						overLength_d = 1'b1;
					if (fifoChar.last)
						state_d = ST_CR;
				end
			end
			ST_CR:
			begin
				if (!txBusy_q)
				begin
					txLoad = 1'b1;
					txLoadChar = CHAR_CR;
					charCount_d = charCount_q + 8'h01;
					state_d = ST_LF;
				end
			end
			ST_LF:
			begin
				if (!txBusy_q)
				begin
					txLoad = 1'b1;
					txLoadChar = CHAR_LF;
					charCount_d = charCount_q + 8'h01;
					state_d = ST_FLUSH;
				end
			end
			ST_FLUSH:
			begin
				if (!txBusy_q)
				begin
					sawCr_d = 1'b0;
					if (isQuery_q)
					begin
						state_d = ST_RX;
						waitCnt_d = 32'(RESP_TIMEOUT_CYCLES);
					end
					else
					begin
						state_d = ST_GAP;
						waitCnt_d = 32'(GAP_CYCLES);
					end
				end
			end
			ST_RX:
			begin
				waitCnt_d = waitCnt_q - 32'h00000001;
				if (rxValid_q)
				begin
					sawCr_d = rxChar_q.ch == CHAR_CR;
					if (sawCr_q && rxChar_q.ch == CHAR_LF)
					begin
						respDone_d = 1'b1;
						state_d = ST_GAP;
						waitCnt_d = 32'(GAP_CYCLES);
					end
				end
				if (waitCnt_q == 32'h00000001 && state_d == ST_RX)
				begin
					respTimeout_d = 1'b1;
					state_d = ST_GAP;
					waitCnt_d = 32'(GAP_CYCLES);
				end
			end
			ST_GAP:
			begin
				// Silent spacing limits the command rate
				baudSel_d = baudSel;
				waitCnt_d = waitCnt_q - 32'h00000001;
				if (waitCnt_q == 32'h00000001)
					state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_q <= ST_IDLE;
			charCount_q <= 8'h00;
			isQuery_q <= 1'b0;
			sawCr_q <= 1'b0;
			waitCnt_q <= 32'h00000000;
			baudSel_q <= SEL_RESET;
			respDone_q <= 1'b0;
			respTimeout_q <= 1'b0;
			overLength_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			charCount_q <= charCount_d;
			isQuery_q <= isQuery_d;
			sawCr_q <= sawCr_d;
			waitCnt_q <= waitCnt_d;
			baudSel_q <= baudSel_d;
			respDone_q <= respDone_d;
			respTimeout_q <= respTimeout_d;
			overLength_q <= overLength_d;
		end
	end

	assign respDone = respDone_q;
	assign respTimeout = respTimeout_q;
	assign overLength = overLength_q;
	assign busy = state_q != ST_IDLE;
	assign baudActive = baudSel_q;

	// ==========================================================
	// Checks
	logic [31:0] quiet_q;

	always_ff @(posedge clk)
	begin
		if (srst)
			quiet_q <= 32'hFFFFFFFF;
		else if (state_q != ST_GAP && state_q != ST_IDLE)
			quiet_q <= 32'h00000000;
		else if (quiet_q != 32'hFFFFFFFF)
			quiet_q <= quiet_q + 32'h00000001;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	sequence seqLfLoaded;
		state_q == ST_LF && !txBusy_q;
	endsequence

	sequence seqFrameOut;
		(txBusy_q && state_q == ST_FLUSH)[*1] ##1 (state_q == ST_FLUSH);
	endsequence

	a_idle_mark: assert property (!txBusy_q |-> txd)
		else $error("line not at mark while transmitter idle");
	a_start_bit: assert property (!txBusy_q && txLoad |=> !txd && txBusy_q)
		else $error("start bit missing after load");
	a_odd_parity: assert property ($rose(txBusy_q) |-> ^txShift_q[8:1])
		else $error("frame parity not odd");
	a_stop_bit: assert property (txDone |-> txShift_q[0] && txBit_q == FRAME_LAST_BIT)
		else $error("frame did not end on tenth bit at mark");
	a_term_order: assert property
		(state_q == ST_CR && !txBusy_q |=> state_q == ST_LF && txBusy_q)
		else $error("LF does not follow CR");
	a_lf_then_flush: assert property (seqLfLoaded |=> seqFrameOut)
		else $error("terminator frame not flushed");
	a_len_limit: assert property (txLoad |-> charCount_q < MAX_CHARS)
		else $error("transmission longer than limit");
	a_quiet_rx: assert property (state_q == ST_RX |-> !txBusy_q && txd)
		else $error("host transmitted during response");
	a_cmd_no_wait: assert property
		(state_q == ST_FLUSH && !txBusy_q && !isQuery_q |=> state_q == ST_GAP)
		else $error("command did not go to silent gap");
	a_query_listen: assert property
		(state_q == ST_FLUSH && !txBusy_q && isQuery_q |=> state_q == ST_RX)
		else $error("query did not wait for response");
	a_gap_spacing: assert property
		(state_q == ST_IDLE && state_d == ST_DATA |-> quiet_q >= 32'(GAP_CYCLES))
		else $error("message started before silent gap elapsed");
	a_baud_steady: assert property
		(state_q inside {ST_DATA, ST_CR, ST_LF, ST_FLUSH, ST_RX} |=> $stable(baudSel_q))
		else $error("line rate changed inside a transmission");

endmodule : serial_host_controller

// [dv/serial_device_model.sv]
// Behavioural model of the instrument's serial port, seen from the host's line.
// Assumes rate is the rate configured on the instrument and rxLine is the host's txd.
module serial_device_model #(
	parameter int unsigned RESP_DELAY_NS = 10000
) (
	input wire logic en,
	input wire logic [1:0] rate,
	input wire logic corruptFirst,
	input wire logic rxLine,
	output logic txLine
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// State seen by the bench
	logic [6:0] gotQ[$];
	int parityErrs;
	logic sawCr;
	logic isQuery;

	function automatic real bitNs(input logic [1:0] r);
		case (r)
			2'h0: return 1.0e9 / 9600.0;
			2'h1: return 1.0e9 / 19200.0;
			2'h2: return 1.0e9 / 38400.0;
			default: return 1.0e9 / 57600.0;
		endcase
	endfunction : bitNs

	// Start, data LSB first, odd parity, stop; flip spoils the parity on purpose
	task automatic sendChar(input logic [6:0] c, input logic flip);
		logic [9:0] f;
		f = {1'b1, (~^c) ^ flip, c, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			txLine = f[i];
			#(bitNs(rate));
		end
	endtask : sendChar

	// ==========================================================
	// Line idles at mark; no handshake lines exist
	initial
	begin
		txLine = 1'b1;
		parityErrs = 0;
		sawCr = 1'b0;
		isQuery = 1'b0;
	end

	// ==========================================================
	// Receive, then answer queries only; never sends while receiving
	always
	begin : rx_loop
		logic [9:0] f;
		@(negedge rxLine iff en);
		#(bitNs(rate) / 2.0);
		for (int i = 0; i < 10; i++)
		begin
			f[i] = rxLine;
			if (i < 9)
				#(bitNs(rate));
		end
		if (f[0] !== 1'b0 || f[9] !== 1'b1 || (^f[8:1]) !== 1'b1)
			parityErrs++;
		gotQ.push_back(f[7:1]);
		if (f[7:1] == 7'h3F)
			isQuery = 1'b1;
		if (sawCr && f[7:1] == 7'h0A)
		begin
			if (isQuery)
			begin
				#(RESP_DELAY_NS);
				sendChar(7'h37, corruptFirst);
				sendChar(7'h38, 1'b0);
				sendChar(7'h0D, 1'b0);
				sendChar(7'h0A, 1'b0);
			end
			// Anything that is not a query is dropped without a reply
			isQuery = 1'b0;
		end
		sawCr = (f[7:1] == 7'h0D);
	end

endmodule : serial_device_model

// [dv/instrument_serial_command_port_bench.sv]
// Self-checking bench for the serial host controller against a device model.
// Assumes the design package and the device model are compiled first.
module instrument_serial_command_port_bench;
	import serial_host_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int unsigned GAP = 200;
	localparam int BIT57 = 16 * int'(DIV_57600);

	logic clk, srst, cmdValid, cmdReady, rxd, txd, rxValid, respDone, respTimeout;
	logic overLength, busy, modelEn, corrupt;
	logic [1:0] baudSel, baudActive, devRate;
	txChar_s cmdChar;
	rxChar_s rxChar;
	rxChar_s rxQ[$];
	int n_mismatch, num_checks, nResp, nTimeout, nClash, nOver;

	// ==========================================================
	// Design and device model
	serial_host_controller #(.GAP_CYCLES(GAP), .RESP_TIMEOUT_CYCLES(200000), .FIFO_DEPTH(8))
	dut_u (.clk(clk), .srst(srst), .baudSel(baudSel), .cmdValid(cmdValid),
		.cmdChar(cmdChar), .cmdReady(cmdReady), .rxd(rxd), .txd(txd), .rxValid(rxValid),
		.rxChar(rxChar), .respDone(respDone), .respTimeout(respTimeout),
		.overLength(overLength), .busy(busy), .baudActive(baudActive));

	serial_device_model #(.RESP_DELAY_NS(10000)) model_u (.en(modelEn), .rate(devRate),
		.corruptFirst(corrupt), .rxLine(txd), .txLine(rxd));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	always @(posedge clk)
	begin
		if (rxValid)
			rxQ.push_back(rxChar);
		nResp += int'(respDone);
		nTimeout += int'(respTimeout);
		nClash += int'(!txd && !rxd);
		nOver += int'(overLength);
	end

	// ==========================================================
	// Shared tasks
	task check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task end_of_test;
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test

	task doReset(input logic [1:0] sel);
		@(negedge clk);
		srst = 1'b1;
		baudSel = sel;
		cmdValid = 1'b0;
		repeat (4) @(negedge clk);
		check(16'({txd, busy, cmdReady, baudActive}), 16'h14);
		srst = 1'b0;
		rxQ.delete();
		model_u.gotQ.delete();
		model_u.parityErrs = 0;
		nResp = 0;
		nTimeout = 0;
		nClash = 0;
		nOver = 0;
	endtask : doReset

	task push(input logic last, input logic [6:0] c);
		@(negedge clk);
		for (int i = 0; i < 100000 && cmdReady !== 1'b1; i++)
			@(negedge clk);
		cmdValid = 1'b1;
		cmdChar = '{last: last, ch: c};
		@(negedge clk);
		cmdValid = 1'b0;
	endtask : push

	task checkSent(input logic [6:0] c);
		check(16'(model_u.gotQ.size()), 16'h3);
		check(16'(model_u.gotQ[0]), 16'(c));
		check(16'({model_u.gotQ[1], model_u.gotQ[2]}), 16'h068A);
		check(16'(model_u.parityErrs), 16'h0);
	endtask : checkSent

	// ==========================================================
	// Scenarios
	task t_rates;
		int n, d;
		logic [15:0] divs[4];
		divs = '{DIV_9600, DIV_19200, DIV_38400, DIV_57600};
		for (int r = 0; r < 4; r++)
		begin
			doReset(2'(r));
			push(1'b1, 7'h55);
			for (n = 0; n < 200 && txd !== 1'b0; n++)
				@(negedge clk);
			d = int'(divs[r]);
			for (n = 0; n < 20000 && txd === 1'b0; n++)
				@(negedge clk);
			check(16'(n >= 15 * d && n <= 16 * d + 2), 16'h1);
			check(16'(baudActive), 16'(r));
		end
	endtask : t_rates

	task t_fill;
		int n;
		doReset(2'h3);
		@(negedge clk);
		cmdValid = 1'b1;
		cmdChar = '{last: 1'b0, ch: 7'h41};
		for (n = 0; n < 20 && cmdReady === 1'b1; n++)
			@(negedge clk);
		repeat (3) @(negedge clk);
		check(16'(n >= 8 && n <= 9 && cmdReady === 1'b0), 16'h1);
		doReset(2'h3);
		check(16'(cmdReady), 16'h1);
	endtask : t_fill

	task t_command;
		int n;
		doReset(2'h3);
		devRate = 2'h3;
		modelEn = 1'b1;
		push(1'b1, 7'h58);
		// Let the sequencer leave idle before offering a new rate
		@(negedge clk);
		baudSel = 2'h0;
		repeat (100) @(negedge clk);
		check(16'(baudActive), 16'h3);
		n = 0;
		for (int i = 0; i < 90000 && busy !== 1'b0; i++)
		begin
			n = (txd === 1'b0) ? 0 : n + 1;
			@(negedge clk);
		end
		check(16'(n >= 2 * BIT57 + GAP - 40 && n <= 2 * BIT57 + GAP + 40), 16'h1);
		checkSent(7'h58);
		check(16'(rxQ.size() + nResp), 16'h0);
		check(16'(nOver), 16'h0);
		check(16'(baudActive), 16'h0);
		baudSel = 2'h3;
	endtask : t_command

	task t_query;
		doReset(2'h3);
		corrupt = 1'b1;
		push(1'b1, 7'h3F);
		for (int i = 0; i < 200000 && nResp == 0; i++)
			@(negedge clk);
		check(16'(nResp), 16'h1);
		check(16'(rxQ.size()), 16'h4);
		check(16'(rxQ[0]), 16'h137);
		check(16'(rxQ[1]), 16'h038);
		check(16'(rxQ[2]), 16'h00D);
		check(16'(rxQ[3]), 16'h00A);
		check(16'(nClash + nTimeout), 16'h0);
		checkSent(7'h3F);
		for (int i = 0; i < GAP + 100 && busy !== 1'b0; i++)
			@(negedge clk);
		check(16'(busy), 16'h0);
	endtask : t_query

	// ==========================================================
	// Main sequence and watchdog
	initial
	begin
		n_mismatch = 0;
		num_checks = 0;
		srst = 1'b1;
		baudSel = 2'h0;
		cmdValid = 1'b0;
		cmdChar = '0;
		modelEn = 1'b0;
		corrupt = 1'b0;
		devRate = 2'h3;
		repeat (4) @(negedge clk);
		srst = 1'b0;
		t_rates();
		t_fill();
		t_command();
		t_query();
		end_of_test();
	end

	initial
	begin
		#4000000;
		n_mismatch++;
		$display("watchdog expired at %0t", $time);
		end_of_test();
	end

endmodule : instrument_serial_command_port_bench
